// File: rtl/lin_serial_pkg.sv
// Register map, field positions, reset values and counts for the serial unit.
// Assumes an 8-bit register port and a single 100 MHz clock.
package lin_serial_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;
    localparam int PORT_E_WIDTH = 6;
    localparam int PIN_TXD = 0;
    localparam int PIN_RXD = 1;

    localparam logic [ADDR_W-1:0] ADDR_PORT_E = 8'h08;
    localparam logic [ADDR_W-1:0] ADDR_PORT_E_DIR = 8'h0c;
    localparam logic [ADDR_W-1:0] ADDR_CTRL_ONE = 8'h13;
    localparam logic [ADDR_W-1:0] ADDR_CTRL_TWO = 8'h14;
    localparam logic [ADDR_W-1:0] ADDR_STATUS = 8'h16;
    localparam logic [ADDR_W-1:0] ADDR_MASK = 8'h17;
    localparam logic [ADDR_W-1:0] ADDR_DATA = 8'h18;
    localparam logic [ADDR_W-1:0] ADDR_BAUD = 8'h19;
    localparam logic [ADDR_W-1:0] ADDR_FINE = 8'h1a;

    // serial_control_one, bit 7 down to bit 0.
    localparam int C1_LOOP = 7;
    localparam int C1_ENABLE = 6;
    localparam int C1_TX_INVERT = 5;
    localparam int C1_LEN9 = 4;
    localparam int C1_WAKE = 3;
    localparam int C1_IDLE_LINE_TYPE = 2;
    localparam int C1_PEN = 1;
    localparam int C1_PTY = 0;

    // serial_control_two.
    localparam int C2_TX_BIT8 = 7;
    localparam int C2_RX_BIT8 = 6;
    localparam int C2_TX_ON = 3;
    localparam int C2_RX_ON = 2;
    localparam int C2_SEND_BREAK = 1;
    localparam int C2_SRC_SEL = 0;

    // baud_rate_select.
    localparam int BR_LIN_BREAK_TX_ENABLE = 7;
    localparam int BR_LIN_BREAK_RX_ENABLE = 6;
    localparam int BR_PRESC_HI = 5;
    localparam int BR_PRESC_LO = 4;
    localparam int BR_DIV_HI = 2;

    // Status and mask layout.
    localparam int ST_TX_EMPTY = 7;
    localparam int ST_TX_DONE = 6;
    localparam int ST_RX_FULL = 5;
    localparam int ST_PARITY = 4;
    localparam int ST_FRAME = 3;
    localparam int ST_BREAK = 2;
    localparam logic [DATA_W-1:0] TX_STATUS_BITS = 8'hc0;

    localparam logic [DATA_W-1:0] RESET_CTRL = 8'h00;
    localparam logic [DATA_W-1:0] RESET_STATUS = 8'hc0;

    localparam logic [3:0] PRESC_DIV_0 = 4'h1;
    localparam logic [3:0] PRESC_DIV_1 = 4'h3;
    localparam logic [3:0] PRESC_DIV_2 = 4'h4;
    localparam logic [3:0] PRESC_DIV_3 = 4'hd;

    localparam logic [3:0] TICK_LAST = 4'hf;
    localparam logic [3:0] TICK_HALF = 4'h7;
    localparam logic [3:0] FRAME_BITS_8 = 4'ha;
    localparam logic [3:0] FRAME_BITS_9 = 4'hb;
    localparam logic [3:0] RX_SAMPLES_8 = 4'h9;
    localparam logic [3:0] RX_SAMPLES_9 = 4'ha;
    localparam logic [3:0] BRK_RX_NORMAL = 4'ha;
    localparam logic [3:0] BRK_RX_LIN = 4'hb;
    localparam logic [3:0] BRK_TX_NORMAL = 4'ha;
    localparam logic [3:0] BRK_TX_LIN = 4'hd;

    typedef enum logic {TX_IDLE, TX_SEND} tx_state_t;
    typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA} rx_state_t;
endpackage : lin_serial_pkg

// File: rtl/lin_serial_unit.sv
// Serial unit with LIN break logic, baud generator and the shared port E pins.
// Assumes synchronous pin inputs, one clock and a one-cycle register port.
//
// Contract
// - Loop mode feeds transmitter into receiver.
// - Enable runs unit; disable sets transmit flags.
// - Inversion flips every transmitted level.
// - Length bit picks 8 or 9 bits.
// - Control one layout fixed, reset clears it.
// - Disabled unit releases pins to the port.
// - Direction selects latch or pin on read.
// - Six port latches, untouched by reset.
// - LIN receive break needs 11 or 12 lows.
// - LIN transmit break is 13 or 14 bits.
// - Without LIN bits, behave as plain serial.
// - Prescaler divisor 1, 3, 4 or 13.
// - Baud divisor is two to the code.
// - One baud rate serves both directions.
// - Baud clock source is selectable.
`timescale 1ns/1ns
module lin_serial_unit (
    input wire logic i_mclk,
    input wire logic i_srst,
    input wire logic [lin_serial_pkg::ADDR_W-1:0] i_addr,
    input wire logic [lin_serial_pkg::DATA_W-1:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [lin_serial_pkg::DATA_W-1:0] o_rdata,
    output logic o_irq,
    input wire logic i_baud_src_tick,
    input wire logic [lin_serial_pkg::PORT_E_WIDTH-1:0] i_pe_in,
    output logic [lin_serial_pkg::PORT_E_WIDTH-1:0] o_pe_out,
    output logic [lin_serial_pkg::PORT_E_WIDTH-1:0] o_pe_oe
);
    import lin_serial_pkg::*;

    logic [DATA_W-1:0] ctrl_one;
    logic [DATA_W-1:0] ctrl_two;
    logic [DATA_W-1:0] baud_rate_select;
    logic [DATA_W-1:0] fine_prescaler_reg;
    logic [DATA_W-1:0] status;
    logic [DATA_W-1:0] mask;
    logic [PORT_E_WIDTH-1:0] port_e_pin_data;
    logic [PORT_E_WIDTH-1:0] port_e_direction;
    logic [8:0] tx_hold;
    logic hold_valid;
    logic [8:0] rx_buf;
    logic [20:0] baud_cnt;
    logic [20:0] baud_total;
    logic baud_tick;
    tx_state_t tx_state;
    logic [10:0] tx_shift;
    logic [3:0] tx_left;
    logic [3:0] tx_phase;
    logic tx_is_brk;
    logic tx_raw;
    logic tx_end;
    rx_state_t rx_state;
    logic [9:0] rx_shift;
    logic [9:0] next_rx_shift;
    logic [3:0] rx_phase;
    logic [3:0] rx_cnt;
    logic rx_line;
    logic rx_finish;
    logic [7:0] low_ticks;
    logic [DATA_W-1:0] set_vec;
    logic [DATA_W-1:0] w1c;
    logic enable;
    logic nine;

    function automatic logic [3:0] presc_div(input logic [1:0] code);
        case (code)
            2'b00: presc_div = PRESC_DIV_0;
            2'b01: presc_div = PRESC_DIV_1;
            2'b10: presc_div = PRESC_DIV_2;
            default: presc_div = PRESC_DIV_3;
        endcase
    endfunction : presc_div

    function automatic logic [3:0] brk_tx_len(input logic lin_break_tx_enable, input logic len9);
        brk_tx_len = (lin_break_tx_enable ? BRK_TX_LIN : BRK_TX_NORMAL) + {3'b000, len9};
    endfunction : brk_tx_len

    function automatic logic [7:0] brk_rx_ticks(input logic lin_break_rx_enable, input logic len9);
        logic [3:0] bits;
        bits = (lin_break_rx_enable ? BRK_RX_LIN : BRK_RX_NORMAL) + {3'b000, len9};
        brk_rx_ticks = {bits - 4'h1, TICK_LAST};
    endfunction : brk_rx_ticks

    function automatic logic [10:0] frame_of(input logic [8:0] d, input logic len9,
                                             input logic parity_enable, input logic parity_type);
        logic [8:0] v;
        logic p;
        v = len9 ? d : {1'b1, d[7:0]};
        p = (len9 ? ^d[7:0] : ^d[6:0]) ^ parity_type;
        if (parity_enable && len9) begin
            v[8] = p;
        end else if (parity_enable) begin
            v[7] = p;
        end
        frame_of = {1'b1, v, 1'b0};
    endfunction : frame_of

    assign enable = ctrl_one[C1_ENABLE];
    assign nine = ctrl_one[C1_LEN9];
    assign w1c = (i_wr && i_addr == ADDR_STATUS) ? i_wdata : '0;

    always_ff @(posedge i_mclk) begin
        if (i_srst) begin
            ctrl_one <= RESET_CTRL;
            baud_rate_select <= RESET_CTRL;
            fine_prescaler_reg <= RESET_CTRL;
            mask <= RESET_CTRL;
            port_e_direction <= '0;
        end else if (i_wr) begin
            case (i_addr)
                ADDR_CTRL_ONE: ctrl_one <= i_wdata;
                ADDR_BAUD: baud_rate_select <= i_wdata;
                ADDR_FINE: fine_prescaler_reg <= i_wdata;
                ADDR_MASK: mask <= i_wdata;
                ADDR_PORT_E_DIR: port_e_direction <= i_wdata[PORT_E_WIDTH-1:0];
                default: ;
            endcase
        end
    end

    // The port latches keep their contents across reset on purpose.
    always_ff @(posedge i_mclk) begin
        if (i_wr && i_addr == ADDR_PORT_E) begin
            port_e_pin_data <= i_wdata[PORT_E_WIDTH-1:0];
        end
    end

    always_ff @(posedge i_mclk) begin
        if (i_srst) begin
            ctrl_two <= RESET_CTRL;
        end else begin
            if (i_wr && i_addr == ADDR_CTRL_TWO) begin
                ctrl_two[C2_TX_BIT8] <= i_wdata[C2_TX_BIT8];
                ctrl_two[C2_TX_ON] <= i_wdata[C2_TX_ON];
                ctrl_two[C2_RX_ON] <= i_wdata[C2_RX_ON];
                ctrl_two[C2_SRC_SEL] <= i_wdata[C2_SRC_SEL];
            end
            // A break request stays pending until the transmitter takes it.
            if (i_wr && i_addr == ADDR_CTRL_TWO && i_wdata[C2_SEND_BREAK]) begin
                ctrl_two[C2_SEND_BREAK] <= 1'b1;
            end else if (tx_state == TX_IDLE && ctrl_two[C2_TX_ON] && enable) begin
                ctrl_two[C2_SEND_BREAK] <= 1'b0;
            end
            if (rx_finish) begin
                ctrl_two[C2_RX_BIT8] <= next_rx_shift[8];
            end
        end
    end

    always_comb begin
        baud_total = 21'(presc_div(baud_rate_select[BR_PRESC_HI:BR_PRESC_LO]))
            * 21'(8'h01 << baud_rate_select[BR_DIV_HI:0])
            * 21'({1'b0, fine_prescaler_reg} + 9'h001);
    end

    // One tick drives both directions, so they never drift apart.
    always_ff @(posedge i_mclk) begin
        if (i_srst || !enable) begin
            baud_cnt <= '0;
        end else if (ctrl_two[C2_SRC_SEL] ? i_baud_src_tick : 1'b1) begin
            baud_cnt <= baud_tick ? '0 : baud_cnt + 21'h000001;
        end
    end
    assign baud_tick = enable && (ctrl_two[C2_SRC_SEL] ? i_baud_src_tick : 1'b1)
        && baud_cnt >= baud_total - 21'h000001;

    always_ff @(posedge i_mclk) begin
        if (i_srst) begin
            hold_valid <= 1'b0;
            tx_hold <= '0;
        end else if (i_wr && i_addr == ADDR_DATA) begin
            hold_valid <= 1'b1;
            tx_hold <= {ctrl_two[C2_TX_BIT8], i_wdata};
        end else if (tx_state == TX_IDLE && ctrl_two[C2_TX_ON] && enable
                     && !ctrl_two[C2_SEND_BREAK]) begin
            hold_valid <= 1'b0;
        end
    end

    assign tx_end = tx_state == TX_SEND && baud_tick && tx_phase == TICK_LAST
        && tx_left == 4'h1;

    always_ff @(posedge i_mclk) begin
        if (i_srst || !enable) begin
            tx_state <= TX_IDLE;
            tx_shift <= '1;
            tx_left <= '0;
            tx_phase <= '0;
            tx_is_brk <= 1'b0;
        end else begin
            case (tx_state)
                TX_IDLE: begin
                    tx_phase <= '0;
                    if (ctrl_two[C2_TX_ON] && ctrl_two[C2_SEND_BREAK]) begin
                        tx_state <= TX_SEND;
                        tx_shift <= '0;
                        tx_left <= brk_tx_len(baud_rate_select[BR_LIN_BREAK_TX_ENABLE], nine);
                        tx_is_brk <= 1'b1;
                    end else if (ctrl_two[C2_TX_ON] && hold_valid) begin
                        tx_state <= TX_SEND;
                        tx_shift <= frame_of(tx_hold, nine, ctrl_one[C1_PEN],
                                             ctrl_one[C1_PTY]);
                        tx_left <= nine ? FRAME_BITS_9 : FRAME_BITS_8;
                        tx_is_brk <= 1'b0;
                    end
                end
                TX_SEND: begin
                    if (baud_tick) begin
                        tx_phase <= tx_phase + 4'h1;
                        if (tx_phase == TICK_LAST) begin
                            tx_shift <= {!tx_is_brk, tx_shift[10:1]};
                            tx_left <= tx_left - 4'h1;
                            if (tx_left == 4'h1) begin
                                tx_state <= TX_IDLE;
                            end
                        end
                    end
                end
                default: tx_state <= TX_IDLE;
            endcase
        end
    end
    assign tx_raw = tx_state == TX_SEND ? tx_shift[0] : 1'b1;

    assign rx_line = ctrl_one[C1_LOOP] ? tx_raw : i_pe_in[PIN_RXD];
    assign next_rx_shift = {rx_line, rx_shift[9:1]};
    assign rx_finish = rx_state == RX_DATA && baud_tick && rx_phase == TICK_LAST
        && rx_cnt == (nine ? RX_SAMPLES_9 : RX_SAMPLES_8) - 4'h1;

    always_ff @(posedge i_mclk) begin
        if (i_srst || !enable || !ctrl_two[C2_RX_ON]) begin
            rx_state <= RX_IDLE;
            rx_phase <= '0;
            rx_cnt <= '0;
            rx_shift <= '0;
        end else if (baud_tick) begin
            case (rx_state)
                RX_IDLE: begin
                    rx_phase <= '0;
                    if (!rx_line) begin
                        rx_state <= RX_START;
                    end
                end
                RX_START: begin
                    rx_phase <= rx_phase + 4'h1;
                    if (rx_phase == TICK_HALF) begin
                        rx_state <= rx_line ? RX_IDLE : RX_DATA;
                        rx_phase <= '0;
                        rx_cnt <= '0;
                    end
                end
                RX_DATA: begin
                    rx_phase <= rx_phase + 4'h1;
                    if (rx_phase == TICK_LAST) begin
                        rx_shift <= next_rx_shift;
                        rx_cnt <= rx_cnt + 4'h1;
                        if (rx_finish) begin
                            rx_state <= RX_IDLE;
                        end
                    end
                end
                default: rx_state <= RX_IDLE;
            endcase
        end
    end

    always_ff @(posedge i_mclk) begin
        if (i_srst) begin
            rx_buf <= '0;
        end else if (rx_finish) begin
            rx_buf <= nine ? next_rx_shift[8:0] : {1'b0, next_rx_shift[8:1]};
        end
    end

    // Low time is measured on its own so a break longer than a frame is seen.
    always_ff @(posedge i_mclk) begin
        if (i_srst || !enable || rx_line) begin
            low_ticks <= '0;
        end else if (baud_tick && low_ticks != 8'hff) begin
            low_ticks <= low_ticks + 8'h01;
        end
    end

    always_comb begin
        set_vec = '0;
        set_vec[ST_TX_EMPTY] = !enable || (tx_state == TX_IDLE && hold_valid
            && ctrl_two[C2_TX_ON] && !ctrl_two[C2_SEND_BREAK]);
        set_vec[ST_TX_DONE] = !enable || (tx_end && !hold_valid);
        set_vec[ST_RX_FULL] = rx_finish;
        set_vec[ST_FRAME] = rx_finish && !rx_line;
        set_vec[ST_PARITY] = rx_finish && ctrl_one[C1_PEN]
            && ((nine ? ^next_rx_shift[8:0] : ^next_rx_shift[8:1]) ^ ctrl_one[C1_PTY]);
        set_vec[ST_BREAK] = baud_tick && !rx_line && ctrl_two[C2_RX_ON]
            && low_ticks == brk_rx_ticks(baud_rate_select[BR_LIN_BREAK_RX_ENABLE], nine);
    end

    // Hardware sets win over a write-one clear in the same cycle.
    always_ff @(posedge i_mclk) begin
        if (i_srst) begin
            status <= RESET_STATUS;
        end else begin
            status <= (status & ~w1c & ~((i_wr && i_addr == ADDR_DATA) ?
                TX_STATUS_BITS : 8'h00)) | set_vec;
        end
    end

    // Transmit interrupts are gated off while the unit is disabled.
    always_ff @(posedge i_mclk) begin
        if (i_srst) begin
            o_irq <= 1'b0;
        end else begin
            o_irq <= |(status & mask & (enable ? 8'hff : ~TX_STATUS_BITS));
        end
    end

    always_ff @(posedge i_mclk) begin
        if (i_srst) begin
            o_rdata <= '0;
        end else if (i_rd) begin
            case (i_addr)
                ADDR_CTRL_ONE: o_rdata <= ctrl_one;
                ADDR_CTRL_TWO: o_rdata <= ctrl_two;
                ADDR_STATUS: o_rdata <= status;
                ADDR_MASK: o_rdata <= mask;
                ADDR_DATA: o_rdata <= rx_buf[7:0];
                ADDR_BAUD: o_rdata <= baud_rate_select;
                ADDR_FINE: o_rdata <= fine_prescaler_reg;
                ADDR_PORT_E_DIR: o_rdata <= {2'b00, port_e_direction};
                ADDR_PORT_E: o_rdata <= {2'b00, (port_e_direction & port_e_pin_data)
                    | (~port_e_direction & i_pe_in)};
                default: o_rdata <= '0;
            endcase
        end else begin
            o_rdata <= '0;
        end
    end

    always_comb begin
        o_pe_oe = port_e_direction;
        o_pe_out = port_e_direction & port_e_pin_data;
        if (enable) begin
            o_pe_oe[PIN_TXD] = 1'b1;
            o_pe_oe[PIN_RXD] = 1'b0;
            o_pe_out[PIN_TXD] = tx_raw ^ ctrl_one[C1_TX_INVERT];
            o_pe_out[PIN_RXD] = 1'b0;
        end
    end

    logic [20:0] gap;
    logic gap_ok;
    always_ff @(posedge i_mclk) begin
        if (i_srst || !enable || (i_wr && (i_addr == ADDR_BAUD || i_addr == ADDR_FINE
            || i_addr == ADDR_CTRL_TWO))) begin
            gap <= '0;
            gap_ok <= 1'b0;
        end else begin
            gap <= baud_tick ? '0 : gap + 21'h000001;
            gap_ok <= gap_ok || baud_tick;
        end
    end

    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (i_srst);

    sequence s_break_go;
        tx_state == TX_IDLE ##1 tx_state == TX_SEND && tx_is_brk;
    endsequence

    a_loop_route: assert property (
        ctrl_one[C1_LOOP] && !i_pe_in[PIN_RXD] && tx_raw |-> rx_line)
        else $error("loop mode does not route transmitter to receiver");
    a_disable_flags: assert property (
        !enable |=> status[ST_TX_EMPTY] && status[ST_TX_DONE] && tx_state == TX_IDLE)
        else $error("disabled unit left transmit flags clear");
    a_tx_invert: assert property (
        enable |-> o_pe_out[PIN_TXD] == (tx_raw ^ ctrl_one[C1_TX_INVERT]) && o_pe_oe[PIN_TXD])
        else $error("transmit pin level not inverted as set");
    a_pins_release: assert property (
        !enable |-> o_pe_oe == port_e_direction)
        else $error("disabled unit still owns port pins");
    a_port_read: assert property (
        i_rd && i_addr == ADDR_PORT_E |=> o_rdata[PORT_E_WIDTH-1:0] ==
        (($past(port_e_direction) & $past(port_e_pin_data))
        | (~$past(port_e_direction) & $past(i_pe_in))))
        else $error("port read ignores direction select");
    a_ctrl_reset: assert property (@(posedge i_mclk) disable iff (1'b0)
        i_srst |=> ctrl_one == RESET_CTRL && baud_rate_select == RESET_CTRL)
        else $error("control register not cleared by reset");
    a_baud_gap: assert property (
        baud_tick && gap_ok && !ctrl_two[C2_SRC_SEL] |-> gap == baud_total - 21'h000001)
        else $error("baud tick spacing differs from divisor product");
    a_break_len: assert property (
        s_break_go |-> !tx_raw && tx_left == brk_tx_len(baud_rate_select[BR_LIN_BREAK_TX_ENABLE], nine))
        else $error("transmitted break length wrong");
    a_break_detect: assert property (
        $rose(status[ST_BREAK]) |-> $past(low_ticks)
        == brk_rx_ticks(baud_rate_select[BR_LIN_BREAK_RX_ENABLE], nine))
        else $error("break flagged at wrong low time");
    a_char_len: assert property (
        rx_finish |-> rx_cnt == (nine ? RX_SAMPLES_9 : RX_SAMPLES_8) - 4'h1)
        else $error("received character length wrong");
endmodule : lin_serial_unit

// File: test/lin_peer.sv
// Remote serial or LIN node: drives the receive line and times the transmit line.
// Assumes the unit's clock and a pulled-up bus line that rests high.
`timescale 1ns/1ns
module lin_peer (
    input wire logic i_mclk,
    input wire logic i_line,
    output logic o_rxd
);
    initial begin
        o_rxd = 1'b1;
    end

    task automatic hold(input logic lvl);
        @(posedge i_mclk);
        o_rxd <= lvl;
    endtask : hold

    // The bit time is an argument so the node can run slower than the unit.
    task automatic send_byte(input logic [7:0] d, input int cyc);
        logic [9:0] f;
        f = {1'b1, d, 1'b0};
        for (int i = 0; i < 10; i++) begin
            @(posedge i_mclk);
            o_rxd <= f[i];
            repeat (cyc - 1) @(posedge i_mclk);
        end
        @(posedge i_mclk);
    endtask : send_byte

    task automatic send_low(input int cyc);
        @(posedge i_mclk);
        o_rxd <= 1'b0;
        repeat (cyc) @(posedge i_mclk);
        o_rxd <= 1'b1;
    endtask : send_low

    // Counts cycles from the falling edge of the line until it is high again.
    task automatic low_len(output int n);
        n = 0;
        for (int i = 0; i < 40000 && i_line !== 1'b0; i++) begin
            @(posedge i_mclk);
            #1;
        end
        while (i_line === 1'b0 && n < 40000) begin
            @(posedge i_mclk);
            #1;
            n++;
        end
    endtask : low_len
endmodule : lin_peer

// File: test/tb.sv
// Self-checking bench for the serial unit: register tasks, timing and break tests.
// Assumes one 100 MHz clock; the remote node model stands on the port E pins.
`timescale 1ns/1ns
module tb;
    import lin_serial_pkg::*;
    logic i_mclk, i_srst, i_wr, i_rd, i_baud_src_tick;
    logic [7:0] i_addr, i_wdata;
    logic [7:0] o_rdata;
    logic o_irq;
    logic [5:0] o_pe_out, o_pe_oe, pe_ext, pin_lvl;
    logic rxd;
    int err_count, n_tests;
    localparam logic [7:0] MC2 [10] = '{8'h08, 8'h08, 8'h08, 8'h08, 8'h08, 8'h08, 8'h09,
                                       8'h08, 8'h08, 8'h08};
    localparam logic [7:0] MBR [10] = '{8'h00, 8'h10, 8'h20, 8'h30, 8'h01, 8'h07, 8'h00,
                                       8'h00, 8'h80, 8'h80};
    localparam logic [9:0] MBK = 10'b1110000000;
    localparam int MBITS [10] = '{1, 1, 1, 1, 1, 1, 1, 10, 13, 14};
    localparam int MTOT [10] = '{1, 3, 4, 13, 2, 128, 2, 1, 1, 1};
    localparam logic [4:0] RXL = 5'b11110;
    localparam logic [4:0] RXM = 5'b11000;
    localparam logic [4:0] RXE = 5'b10101;
    localparam int RXH [5] = '{21, 21, 23, 23, 25};

    // Undriven pins take the external level, so a released pin never shows stale drive.
    assign pin_lvl = (o_pe_oe & o_pe_out) | (~o_pe_oe & {pe_ext[5:2], rxd, pe_ext[0]});

    lin_serial_unit DUT (.i_mclk(i_mclk), .i_srst(i_srst), .i_addr(i_addr),
        .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_irq(o_irq),
        .i_baud_src_tick(i_baud_src_tick), .i_pe_in(pin_lvl), .o_pe_out(o_pe_out),
        .o_pe_oe(o_pe_oe));
    lin_peer peer (.i_mclk(i_mclk), .i_line(pin_lvl[0]), .o_rxd(rxd));

    initial begin
        i_mclk = 1'b0;
        forever #5 i_mclk = ~i_mclk;
    end

    always @(posedge i_mclk) begin
        i_baud_src_tick <= ~i_baud_src_tick;
    end

    task automatic test_done();
        $display("checks %0d, mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : test_done

    task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
        n_tests++;
        if (got !== exp) begin
            err_count++;
            $display("unexpected %s: expected %h, seen %h", nm, exp, got);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_mclk);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_mclk);
        i_wr <= 1'b0;
    endtask : wr

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] m, input logic [7:0] exp,
                          input string nm);
        @(posedge i_mclk);
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_mclk);
        i_rd <= 1'b0;
        #1;
        chk(nm, exp & m, o_rdata & m);
    endtask : rd_chk

    task automatic do_reset();
        @(posedge i_mclk);
        i_srst <= 1'b1;
        repeat (16) @(posedge i_mclk);
        i_srst <= 1'b0;
    endtask : do_reset

    task automatic cfg(input logic [7:0] c2, input logic [7:0] br, input logic [7:0] c1);
        do_reset();
        wr(ADDR_CTRL_TWO, c2);
        wr(ADDR_BAUD, br);
        wr(ADDR_FINE, 8'h00);
        wr(ADDR_CTRL_ONE, c1);
    endtask : cfg

    // A frame may begin anywhere in a baud period, so one period of slack is allowed.
    task automatic meas(input int i);
        int n;
        int exp;
        cfg(MC2[i], MBR[i], {3'b010, MBITS[i] == 14, 4'h0});
        if (MBK[i]) begin
            wr(ADDR_CTRL_TWO, MC2[i] | 8'h02);
        end else begin
            wr(ADDR_DATA, 8'hff);
        end
        peer.low_len(n);
        exp = MBITS[i] * 16 * MTOT[i];
        n_tests++;
        if (n <= exp - MTOT[i] || n > exp + MTOT[i]) begin
            err_count++;
            $display("unexpected low time %0d: expected %0d, seen %0d", i, exp, n);
        end
    endtask : meas

    initial begin
        #400000;
        err_count++;
        $display("watchdog expired");
        test_done();
    end

    initial begin
        i_srst = 1'b1;
        i_wr = 1'b0;
        i_rd = 1'b0;
        i_addr = 8'h00;
        i_wdata = 8'h00;
        i_baud_src_tick = 1'b0;
        pe_ext = 6'h35;
        err_count = 0;
        n_tests = 0;
        do_reset();
        rd_chk(ADDR_CTRL_ONE, 8'hff, RESET_CTRL, "control one reset");
        rd_chk(ADDR_BAUD, 8'hff, 8'h00, "baud select reset");
        chk("pin enables", 8'h00, {2'b00, o_pe_oe});
        wr(ADDR_CTRL_ONE, 8'hbf);
        rd_chk(ADDR_CTRL_ONE, 8'hff, 8'hbf, "control one");
        wr(ADDR_PORT_E_DIR, 8'h3f);
        wr(ADDR_PORT_E, 8'h2a);
        do_reset();
        wr(ADDR_PORT_E_DIR, 8'h3f);
        rd_chk(ADDR_PORT_E, 8'h3f, 8'h2a, "port latch");
        chk("pin drive", 8'h2a, {2'b00, o_pe_out});
        wr(ADDR_PORT_E_DIR, 8'h00);
        rd_chk(ADDR_PORT_E, 8'h3f, {2'b00, pe_ext[5:2], 1'b1, pe_ext[0]}, "port pins");
        wr(ADDR_PORT_E_DIR, 8'h3f);
        wr(ADDR_CTRL_ONE, 8'h40);
        rd_chk(ADDR_PORT_E, 8'h3f, 8'h2a, "port latch enabled");
        chk("serial pin enables", 8'h01, {6'h00, o_pe_oe[1:0]});
        $display("test registers and port done");
        cfg(8'h0c, 8'h00, 8'h40);
        wr(ADDR_DATA, 8'h00);
        wr(ADDR_DATA, 8'h00);
        rd_chk(ADDR_STATUS, 8'hc0, 8'h00, "tx flags busy");
        wr(ADDR_CTRL_ONE, 8'h00);
        rd_chk(ADDR_STATUS, 8'hc0, 8'hc0, "tx flags disabled");
        cfg(8'h08, 8'h00, 8'h60);
        #1;
        chk("inverted idle", 8'h00, {7'h00, o_pe_out[0]});
        $display("test enable and inversion done");
        cfg(8'h0c, 8'h00, 8'hc0);
        peer.hold(1'b0);
        wr(ADDR_DATA, 8'ha5);
        repeat (200) @(posedge i_mclk);
        rd_chk(ADDR_DATA, 8'hff, 8'ha5, "loop data");
        peer.hold(1'b1);
        // Even parity over the low seven bits replaces bit 7 of the character.
        cfg(8'h0c, 8'h00, 8'hc2);
        wr(ADDR_DATA, 8'h25);
        repeat (200) @(posedge i_mclk);
        rd_chk(ADDR_DATA, 8'hff, 8'ha5, "loop parity data");
        rd_chk(ADDR_STATUS, 8'h18, 8'h00, "loop parity flags");
        cfg(8'h0c, 8'h00, 8'h40);
        peer.send_byte(8'h3c, 17);
        repeat (20) @(posedge i_mclk);
        rd_chk(ADDR_DATA, 8'hff, 8'h3c, "rx data");
        $display("test loop and receive done");
        for (int i = 0; i < 10; i++) begin
            meas(i);
        end
        $display("test baud and break length done");
        for (int i = 0; i < 5; i++) begin
            cfg(8'h0c, {1'b0, RXL[i], 6'h00}, {3'b010, RXM[i], 4'h0});
            wr(ADDR_MASK, 8'h04);
            wr(ADDR_STATUS, 8'hff);
            peer.send_low(RXH[i] * 8);
            repeat (40) @(posedge i_mclk);
            rd_chk(ADDR_STATUS, 8'h04, {5'h00, RXE[i], 2'b00}, "break flag");
            chk("irq raised", {7'h00, RXE[i]}, {7'h00, o_irq});
            wr(ADDR_STATUS, 8'h04);
            repeat (3) @(posedge i_mclk);
            #1;
            chk("irq cleared", 8'h00, {7'h00, o_irq});
        end
        $display("test break detect and interrupt done");
        test_done();
    end
endmodule : tb
